/* common/cb2_map.svh */
// offsets, field positions, reset values and counts for the circular buffer mode 2 manager
// Overview of operation
// [RULE1] mode two: pingpong clear, circ two set
// [RULE2] descriptor is four words N to N+3
// [RULE3] each message writes info then time-tag
// [RULE4] bad message leaves info pointer unchanged
// [RULE5] good receive data stored from current pointer
// [RULE6] info pointer plus one, test, plus one
// [RULE7] full count restores info and data pointers
// [RULE8] interrupt only when whole block completes
// [RULE9] host should set errored data discard
// [RULE10] control bits 7:4 give count code
// [RULE11] host base has enough trailing zeros
// [RULE12] host allots two info words per message
// [RULE13] host sizes data for 32 words/message
// [RULE14] info pointer stays readable by host
// [RULE15] 128 messages use eight pointer bits
// [RULE16] command selects descriptor to fetch first
// [RULE17] separate buffers per direction and subaddress
// [RULE18] transmit fetches data from current pointer
// [RULE19] block done with both enables raises interrupt
// [RULE20] broadcast transmit writes info, keeps pointers
// [RULE21] current pointer moves past last word
`ifndef CB2_MAP_SVH
`define CB2_MAP_SVH

// ==========================================================
// register port offsets
`define CB2_REG_CTRL        3'h0
`define CB2_REG_DESC_BASE   3'h1
`define CB2_REG_STATUS      3'h2
`define CB2_REG_LAST_INFO   3'h3
`define CB2_REG_BLOCKS      3'h4

// ==========================================================
// register fields and reset values
`define CB2_CTRL_IRQ_EN     0
`define CB2_CTRL_DISCARD    1
`define CB2_CTRL_RESET      2'h0
`define CB2_DESC_BASE_RESET 16'h0000

// ==========================================================
// descriptor word offsets and control word fields
`define CB2_DW_CTRL         2'h0
`define CB2_DW_START        2'h1
`define CB2_DW_CURRENT      2'h2
`define CB2_DW_INFO         2'h3
`define CB2_CW_PINGPONG     15
`define CB2_CW_CIRC_TWO     14
`define CB2_CW_CIRC_ONE     13
`define CB2_CW_BUF_PTR      12
`define CB2_CW_IRQ          11
`define CB2_CW_CODE_MSB     7
`define CB2_CW_CODE_LSB     4

// ==========================================================
// message limits
`define CB2_MAX_WORDS       32

`endif

/* common/cb2_pkg.sv */
// types shared by the circular buffer mode 2 manager
`include "cb2_map.svh"
package cb2_pkg;

  typedef enum logic [3:0] {
    S_IDLE, S_FETCH_REQ, S_FETCH_WAIT, S_FETCH_CAP, S_WAIT_MSG, S_TX_WAIT, S_TX_CAP,
    S_WR_INFO, S_WR_TAG, S_STORE, S_WR_CUR, S_WR_INFO_PTR
  } cb2_state_t;

  typedef struct packed {
    cb2_state_t  state;
    logic [1:0]  widx;
    logic [15:0] desc;
    logic [15:0] cw;
    logic [15:0] start_ptr;
    logic [15:0] cur_ptr;
    logic [15:0] info_ptr;
    logic        tr;
    logic        bcast;
    logic [5:0]  cnt;
    logic [5:0]  sidx;
    logic        err;
    logic        busy_ill;
    logic        full;
    logic [15:0] info;
    logic [15:0] tag;
    logic [15:0] ram_addr;
    logic [15:0] ram_wdata;
    logic        ram_we;
    logic        ram_re;
    logic [15:0] tx_word;
    logic        tx_word_valid;
    logic        irq;
    logic        mode_active;
    logic [15:0] last_info_ptr;
    logic [15:0] blocks;
  } cb2_core_t;

  typedef struct packed {
    logic [1:0]  ctrl;
    logic [15:0] desc_base;
    logic [15:0] rdata;
  } cb2_regs_t;

endpackage : cb2_pkg

/* hdl/cb2_word_buf.sv */
// holding store for received words until the message completes
`timescale 1ns/100ps
module cb2_word_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side, combinational
  input  wire logic [AW-1:0]    rd_idx,
  output logic      [WIDTH-1:0] rd_data
);

  logic [DEPTH-1:0][WIDTH-1:0] mem;
  logic [DEPTH-1:0][WIDTH-1:0] next_mem;

  always_comb begin
    next_mem = mem;
    if (wr_en) begin
      next_mem[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem <= '0;
    end else begin
      mem <= next_mem;
    end
  end

  assign rd_data = mem[rd_idx];

endmodule : cb2_word_buf

/* hdl/cb2_regs.sv */
// host register port of the circular buffer mode 2 manager
`timescale 1ns/100ps
`include "cb2_map.svh"
module cb2_regs
  import cb2_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // settings to the core
  output logic             irq_enable,
  output logic             discard_errored,
  output logic      [15:0] desc_base,
  // state from the core
  input  wire logic        busy,
  input  wire logic        mode_active,
  input  wire logic [15:0] last_info_ptr,
  input  wire logic [15:0] blocks
);

  cb2_regs_t r;
  cb2_regs_t next_r;

  always_comb begin
    next_r = r;
    next_r.rdata = 16'h0000;
    if (reg_wr) begin
      if (reg_addr == `CB2_REG_CTRL) begin
        next_r.ctrl = reg_wdata[1:0];
      end else if (reg_addr == `CB2_REG_DESC_BASE) begin
        next_r.desc_base = reg_wdata;
      end
    end
    // unmapped addresses read as zero
    if (reg_rd) begin
      if (reg_addr == `CB2_REG_CTRL) begin
        next_r.rdata = {14'h0000, r.ctrl};
      end else if (reg_addr == `CB2_REG_DESC_BASE) begin
        next_r.rdata = r.desc_base;
      end else if (reg_addr == `CB2_REG_STATUS) begin
        next_r.rdata = {14'h0000, mode_active, busy};
      end else if (reg_addr == `CB2_REG_LAST_INFO) begin
        next_r.rdata = last_info_ptr;
      end else if (reg_addr == `CB2_REG_BLOCKS) begin
        next_r.rdata = blocks;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r.ctrl      <= `CB2_CTRL_RESET;
      r.desc_base <= `CB2_DESC_BASE_RESET;
      r.rdata     <= 16'h0000;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata       = r.rdata;
  assign irq_enable      = r.ctrl[`CB2_CTRL_IRQ_EN];
  assign discard_errored = r.ctrl[`CB2_CTRL_DISCARD];
  assign desc_base       = r.desc_base;

endmodule : cb2_regs

/* hdl/cb2_buffer_mgr.sv */
// descriptor driven buffer manager for one terminal in circular buffer mode 2
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "cb2_map.svh"
module cb2_buffer_mgr
  import cb2_pkg::*;
#(
  parameter int MAX_WORDS = `CB2_MAX_WORDS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // host register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // shared ram, read data one cycle after ram_re
  output logic      [15:0] ram_addr,
  output logic      [15:0] ram_wdata,
  output logic             ram_we,
  output logic             ram_re,
  input  wire logic [15:0] ram_rdata,
  // command from the protocol engine
  input  wire logic        msg_start,
  input  wire logic        cmd_tr,
  input  wire logic [4:0]  cmd_subaddr,
  input  wire logic [4:0]  cmd_word_count,
  input  wire logic        cmd_bcast,
  // received words
  input  wire logic        rx_word_valid,
  input  wire logic [15:0] rx_word,
  // transmit words
  input  wire logic        tx_word_req,
  output logic             tx_word_valid,
  output logic      [15:0] tx_word,
  // message completion
  input  wire logic        msg_done,
  input  wire logic        msg_error,
  input  wire logic        msg_busy,
  input  wire logic        msg_illegal,
  input  wire logic [15:0] msg_info_word,
  input  wire logic [15:0] msg_time_tag,
  // status
  output logic             mode_active,
  output logic             message_irq_out
);

  // ==========================================================
  // helpers

  // low bits counted for a given count code
  function automatic logic [15:0] cb2_count_mask(input logic [3:0] code);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      m[i] = (5'(i) < {1'b0, code});
    end
    return m;
  endfunction : cb2_count_mask

  // full count: every counted low bit set after the first increment
  function automatic logic cb2_is_full(input logic [15:0] ptr, input logic [15:0] m);
    return (ptr & m) == m;
  endfunction : cb2_is_full

  // word address inside a buffer
  function automatic logic [15:0] cb2_word_addr(input logic [15:0] base, input logic [5:0] idx);
    return base + {10'h000, idx};
  endfunction : cb2_word_addr

  // ==========================================================
  // register port and receive holding store

  logic        irq_enable;
  logic        discard_errored;
  logic [15:0] desc_base;
  logic        buf_wr;
  logic [15:0] buf_rdata;

  cb2_core_t r;
  cb2_core_t next_r;

  cb2_regs u_regs (
    .clk             (clk),
    .reset           (reset),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .irq_enable      (irq_enable),
    .discard_errored (discard_errored),
    .desc_base       (desc_base),
    .busy            (r.state != S_IDLE),
    .mode_active     (r.mode_active),
    .last_info_ptr   (r.last_info_ptr),
    .blocks          (r.blocks)
  );

  // holding store lets data reach ram only at completion, never for busy or illegal, and for errored only with discard off
  cb2_word_buf #(
    .WIDTH (16),
    .DEPTH (MAX_WORDS),
    .AW    (5)
  ) u_buf (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (buf_wr),
    .wr_idx  (r.cnt[4:0]),
    .wr_data (rx_word),
    .rd_idx  (r.sidx[4:0]),
    .rd_data (buf_rdata)
  );

  // ==========================================================
  // sequencer

  logic [15:0] mask;
  logic [15:0] info_inc;
  logic        info_full;
  logic [15:0] cur_next;
  logic        store_ok;

  always_comb begin
    // [RULE10] count code selects bits
    mask      = cb2_count_mask(r.cw[`CB2_CW_CODE_MSB:`CB2_CW_CODE_LSB]);
    info_inc  = r.info_ptr + 16'h0001;
    info_full = cb2_is_full(info_inc, mask);
    // full count sends the data pointer back to the buffer start
    cur_next  = info_full ? r.start_ptr : cb2_word_addr(r.cur_ptr, r.cnt);
    store_ok = !r.tr && !r.busy_ill && !(r.err && discard_errored) && (r.cnt != 6'h00);
    buf_wr   = (r.state == S_WAIT_MSG) && rx_word_valid && !r.tr && (r.cnt < 6'(MAX_WORDS));
    next_r               = r;
    next_r.ram_we        = 1'b0;
    next_r.ram_re        = 1'b0;
    next_r.tx_word_valid = 1'b0;
    next_r.irq           = 1'b0;
    case (r.state)
      S_IDLE: begin
        if (msg_start) begin
          // [RULE16] descriptor from direction, subaddress
          // [RULE17] direction splits descriptor pairs
          next_r.desc  = desc_base + {8'h00, cmd_tr, cmd_subaddr, 2'b00};
          next_r.tr    = cmd_tr;
          next_r.bcast = cmd_bcast;
          next_r.widx  = `CB2_DW_CTRL;
          next_r.cnt   = 6'h00;
          next_r.state = S_FETCH_REQ;
        end
      end
      S_FETCH_REQ: begin
        // [RULE2] words at N through N+3
        next_r.ram_re   = 1'b1;
        next_r.ram_addr = r.desc + {14'h0000, r.widx};
        next_r.state    = S_FETCH_WAIT;
      end
      S_FETCH_WAIT: begin
        next_r.state = S_FETCH_CAP;
      end
      S_FETCH_CAP: begin
        next_r.state = S_FETCH_REQ;
        next_r.widx  = r.widx + 2'h1;
        if (r.widx == `CB2_DW_CTRL) begin
          next_r.cw = ram_rdata;
        end else if (r.widx == `CB2_DW_START) begin
          next_r.start_ptr = ram_rdata;
        end else if (r.widx == `CB2_DW_CURRENT) begin
          next_r.cur_ptr = ram_rdata;
        end else begin
          next_r.info_ptr = ram_rdata;
          // [RULE1] circ one and pointer bit ignored
          if (!r.cw[`CB2_CW_PINGPONG] && r.cw[`CB2_CW_CIRC_TWO]) begin
            next_r.mode_active = 1'b1;
            next_r.state       = S_WAIT_MSG;
          end else begin
            // other buffer modes are served elsewhere
            next_r.mode_active = 1'b0;
            next_r.state       = S_IDLE;
          end
        end
      end
      S_WAIT_MSG: begin
        if (msg_done) begin
          next_r.err      = msg_error;
          next_r.busy_ill = msg_busy || msg_illegal;
          next_r.info     = msg_info_word;
          next_r.tag      = msg_time_tag;
          next_r.state    = S_WR_INFO;
        end else if (buf_wr) begin
          next_r.cnt = r.cnt + 6'h01;
        end else if (tx_word_req && r.tr && !r.bcast && (r.cnt < 6'(MAX_WORDS))) begin
          // [RULE18] transmit words from current pointer
          next_r.ram_re   = 1'b1;
          next_r.ram_addr = cb2_word_addr(r.cur_ptr, r.cnt);
          next_r.state    = S_TX_WAIT;
        end
      end
      S_TX_WAIT: begin
        next_r.state = S_TX_CAP;
      end
      S_TX_CAP: begin
        next_r.tx_word       = ram_rdata;
        next_r.tx_word_valid = 1'b1;
        next_r.cnt           = r.cnt + 6'h01;
        next_r.state         = S_WAIT_MSG;
      end
      S_WR_INFO: begin
        // [RULE3] info word at pointer
        next_r.ram_we    = 1'b1;
        next_r.ram_addr  = r.info_ptr;
        next_r.ram_wdata = r.info;
        next_r.state     = S_WR_TAG;
      end
      S_WR_TAG: begin
        // [RULE3] time-tag at next address
        next_r.ram_we    = 1'b1;
        next_r.ram_addr  = info_inc;
        next_r.ram_wdata = r.tag;
        next_r.sidx      = 6'h00;
        if (r.tr && r.bcast) begin
          // [RULE20] broadcast transmit keeps pointers
          next_r.state = S_IDLE;
        end else if (store_ok) begin
          next_r.state = S_STORE;
        end else if (r.err || r.busy_ill) begin
          // [RULE4] bad message, pointer unchanged
          next_r.state = S_IDLE;
        end else begin
          next_r.state = S_WR_CUR;
        end
      end
      S_STORE: begin
        // [RULE5] data from current pointer
        next_r.ram_we    = 1'b1;
        next_r.ram_addr  = cb2_word_addr(r.cur_ptr, r.sidx);
        next_r.ram_wdata = buf_rdata;
        next_r.sidx      = r.sidx + 6'h01;
        if (r.sidx + 6'h01 == r.cnt) begin
          // errored data kept only if discard is off; pointers still frozen
          // [RULE4] errored store leaves pointers
          next_r.state = (r.err || r.busy_ill) ? S_IDLE : S_WR_CUR;
        end
      end
      S_WR_CUR: begin
        // [RULE6] first increment then full test
        // [RULE15] code eight tests eight bits
        next_r.full    = info_full;
        // [RULE21] past last word moved
        next_r.cur_ptr = cur_next;
        if (info_full) begin
          // [RULE7] restore base and start pointer
          next_r.info_ptr = info_inc & ~mask;
        end else begin
          // [RULE6] second increment
          next_r.info_ptr = info_inc + 16'h0001;
        end
        next_r.ram_we    = 1'b1;
        next_r.ram_addr  = r.desc + {14'h0000, `CB2_DW_CURRENT};
        next_r.ram_wdata = cur_next;
        next_r.state     = S_WR_INFO_PTR;
      end
      S_WR_INFO_PTR: begin
        // [RULE14] pointer written back and mirrored
        next_r.ram_we        = 1'b1;
        next_r.ram_addr      = r.desc + {14'h0000, `CB2_DW_INFO};
        next_r.ram_wdata     = r.info_ptr;
        next_r.last_info_ptr = r.info_ptr;
        if (r.full) begin
          next_r.blocks = r.blocks + 16'h0001;
          // [RULE8] only at block completion
          // [RULE19] both enables needed
          next_r.irq = r.cw[`CB2_CW_IRQ] && irq_enable;
        end
        next_r.state = S_IDLE;
      end
      default: begin
        next_r.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r       <= '0;
      r.state <= S_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs

  assign ram_addr        = r.ram_addr;
  assign ram_wdata       = r.ram_wdata;
  assign ram_we          = r.ram_we;
  assign ram_re          = r.ram_re;
  assign tx_word_valid   = r.tx_word_valid;
  assign tx_word         = r.tx_word;
  assign mode_active     = r.mode_active;
  assign message_irq_out = r.irq;

endmodule : cb2_buffer_mgr

/* test/cb2_buffer_mgr_assertions.sv */
// port assertions for the circular buffer mode 2 manager
`timescale 1ns/100ps
module cb2_buffer_mgr_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // watched ports
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] ram_addr,
  input wire logic        ram_we,
  input wire logic        ram_re,
  input wire logic        msg_start,
  input wire logic        msg_done,
  input wire logic        tx_word_req,
  input wire logic        tx_word_valid,
  input wire logic        message_irq_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ==========================================================
  // sequences
  sequence fetch_s;
    ##2 ram_re ##3 ram_re ##3 ram_re ##3 ram_re;
  endsequence
  sequence info_tag_s;
    ##2 ram_we ##1 ram_we;
  endsequence

  // ==========================================================
  // properties
  a_fetch_four: assert property (msg_start |-> fetch_s)
    else $error("descriptor fetch is not four spaced reads");
  a_fetch_addr: assert property (msg_start |-> ##5 (ram_addr == $past(ram_addr, 3) + 16'h1))
    else $error("descriptor words not consecutive");
  a_info_tag: assert property (msg_done |-> info_tag_s)
    else $error("info and tag writes missing after completion");
  a_irq_pulse: assert property (message_irq_out |=> !message_irq_out)
    else $error("block interrupt longer than one cycle");
  a_irq_after_ptrs: assert property (message_irq_out |-> ram_we && $past(ram_we))
    else $error("block interrupt not beside pointer writes");
  a_tx_latency: assert property (tx_word_valid |-> $past(tx_word_req, 3) && $past(ram_re, 2))
    else $error("transmit word without fetch three cycles after request");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data outside its cycle");
  a_ram_excl: assert property (!(ram_we && ram_re))
    else $error("ram read and write together");
  a_re_pulse: assert property (ram_re |=> !ram_re)
    else $error("ram read strobe longer than one cycle");
endmodule : cb2_buffer_mgr_assertions

bind cb2_buffer_mgr cb2_buffer_mgr_assertions u_chk (.clk, .reset, .reg_rd, .reg_rdata, .ram_addr, .ram_we,
  .ram_re, .msg_start, .msg_done, .tx_word_req, .tx_word_valid, .message_irq_out);

/* test/cb2_ram_model.sv */
// shared ram standing behind the manager's master port
`timescale 1ns/100ps
module cb2_ram_model (
  // clock
  input  wire logic        clk,
  // master port
  input  wire logic [15:0] ram_addr,
  input  wire logic [15:0] ram_wdata,
  input  wire logic        ram_we,
  input  wire logic        ram_re,
  output logic      [15:0] ram_rdata
);
  logic [15:0] mem [0:65535];

  initial ram_rdata = 16'h0;
  // data stands one cycle only; the bus churns after so a late sample is caught
  always @(posedge clk) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
    ram_rdata <= ram_re ? mem[ram_addr] : ~ram_rdata;
  end
endmodule : cb2_ram_model

/* test/tb.sv */
// self-checking bench for the circular buffer mode 2 manager
`timescale 1ns/100ps
module tb;
  // ==========================================================
  // signals
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        msg_start = 1'b0;
  logic        cmd_tr = 1'b0;
  logic        cmd_bcast = 1'b0;
  logic [4:0]  cmd_subaddr = 5'h0;
  logic [4:0]  cmd_word_count = 5'h0;
  logic        rx_word_valid = 1'b0;
  logic [15:0] rx_word = 16'h0;
  logic        tx_word_req = 1'b0;
  logic        msg_done = 1'b0;
  logic        msg_error = 1'b0;
  logic        msg_busy = 1'b0;
  logic        msg_illegal = 1'b0;
  logic [15:0] msg_info_word = 16'h0;
  logic [15:0] msg_time_tag = 16'h0;
  logic [15:0] reg_rdata, ram_addr, ram_wdata, ram_rdata, tx_word;
  logic        ram_we, ram_re, tx_word_valid, mode_active, message_irq_out;
  integer      seed = 32'hb4936d70;
  int          fails = 0;
  int          total_checks = 0;
  logic [15:0] irqs = 16'h0;
  logic [15:0] e_irq, e_blk, e_cw, e_start, e_cur, e_info, dn, d;
  logic        e_tr, irq_en, disc;
  logic [4:0]  e_sub;
  logic [15:0] dq [0:31];

  cb2_buffer_mgr dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ram_addr, .ram_wdata, .ram_we, .ram_re, .ram_rdata, .msg_start, .cmd_tr, .cmd_subaddr,
    .cmd_word_count, .cmd_bcast, .rx_word_valid, .rx_word, .tx_word_req, .tx_word_valid, .tx_word,
    .msg_done, .msg_error, .msg_busy, .msg_illegal, .msg_info_word, .msg_time_tag, .mode_active,
    .message_irq_out);
  cb2_ram_model ram (.clk, .ram_addr, .ram_wdata, .ram_we, .ram_re, .ram_rdata);

  initial forever #4 clk = ~clk;
  always @(posedge clk) if (message_irq_out === 1'b1) irqs <= irqs + 16'h1;

  // ==========================================================
  // tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task wr(input logic [2:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [2:0] a, output logic [15:0] q);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
    @(posedge clk);
  endtask : rd

  task setup(input logic tr, input logic [15:0] cw, input logic [15:0] st, input logic [15:0] mb);
    dn = 16'h0100 + {8'h0, tr, e_sub, 2'b00};
    e_tr = tr;
    e_cw = cw;
    e_start = st;
    e_cur = st;
    e_info = mb;
    ram.mem[dn] = cw;
    ram.mem[dn + 16'h1] = st;
    ram.mem[dn + 16'h2] = st;
    ram.mem[dn + 16'h3] = mb;
  endtask : setup

  // one message; words per message stay within 32
  task run(input logic bc, input int n, input logic [2:0] bad);
    logic [15:0] mk, inf, tg;
    logic        good;
    inf = 16'($random(seed));
    tg = 16'($random(seed));
    good = (bad == 3'h0) && !(e_tr && bc);
    mk = (16'h1 << e_cw[7:4]) - 16'h1;
    msg_start <= 1'b1;
    cmd_tr <= e_tr;
    cmd_subaddr <= e_sub;
    cmd_bcast <= bc;
    cmd_word_count <= n[4:0];
    @(posedge clk);
    msg_start <= 1'b0;
    repeat (14) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      if (!e_tr) begin
        dq[i] = 16'($random(seed));
        rx_word_valid <= 1'b1;
        rx_word <= dq[i];
        @(posedge clk);
      end else if (!bc) begin
        ram.mem[e_cur + i] = 16'($random(seed));
        tx_word_req <= 1'b1;
        @(posedge clk);
        tx_word_req <= 1'b0;
        // word and its valid stand in the third cycle after the request
        repeat (2) @(posedge clk);
        #1;
        chk(tx_word, ram.mem[e_cur + i]);
        chk({15'h0, tx_word_valid}, 16'h1);
        @(posedge clk);
      end
    end
    rx_word_valid <= 1'b0;
    msg_done <= 1'b1;
    {msg_illegal, msg_busy, msg_error} <= bad;
    msg_info_word <= inf;
    msg_time_tag <= tg;
    @(posedge clk);
    msg_done <= 1'b0;
    d = 16'h1;
    for (int k = 0; k < 80 && d[0] !== 1'b0; k++) rd(3'h2, d);
    chk(d & 16'h3, 16'h2);
    chk({15'h0, mode_active}, 16'h1);
    chk(ram.mem[e_info], inf);
    chk(ram.mem[e_info + 16'h1], tg);
    // errored data is kept when discard is off, pointers still frozen
    if ((good || (bad == 3'h1 && !disc)) && !e_tr) begin
      for (int i = 0; i < n; i++) chk(ram.mem[e_cur + i], dq[i]);
    end
    if (good && (((e_info + 16'h1) & mk) == mk)) begin
      e_info = (e_info + 16'h1) & ~mk;
      e_cur = e_start;
      e_blk++;
      e_irq = e_irq + {15'h0, e_cw[11] & irq_en};
    end else if (good) begin
      e_info = e_info + 16'h2;
      e_cur = e_cur + n[15:0];
    end
    chk(ram.mem[dn + 16'h2], e_cur);
    chk(ram.mem[dn + 16'h3], e_info);
    chk(irqs, e_irq);
  endtask : run

  // ==========================================================
  // sequence of tests
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    close_out();
  end

  initial begin
    e_irq = 16'h0;
    e_blk = 16'h0;
    irq_en = 1'b1;
    disc = 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(3'h0, d);
    chk(d, 16'h0);
    wr(3'h0, 16'h3);
    rd(3'h0, d);
    chk(d, 16'h3);
    rd(3'h5, d);
    chk(d, 16'h0);
    wr(3'h1, 16'h0100);
    rd(3'h1, d);
    chk(d, 16'h0100);
    e_sub = 5'($random(seed));
    // pingpong set: not this mode, manager must go back idle
    setup(1'b0, 16'hc020, 16'h2000, 16'h3000);
    msg_start <= 1'b1;
    cmd_subaddr <= e_sub;
    @(posedge clk);
    msg_start <= 1'b0;
    repeat (14) @(posedge clk);
    rd(3'h2, d);
    chk(d & 16'h3, 16'h0);
    chk({15'h0, mode_active}, 16'h0);
    for (int c = 2; c <= 3; c++) begin
      setup(1'b0, 16'h7800 | 16'(c << 4), 16'h2000, 16'h3000);
      for (int m = 0; m < (1 << (c - 1)) + 3; m++)
        run(1'b0, ($random(seed) & 31) + 1, (m >= 1 && m <= 3) ? 3'(1 << (m - 1)) : 3'h0);
    end
    setup(1'b1, 16'h4820, 16'h4000, 16'h5004);
    run(1'b0, 32, 3'h0);
    run(1'b1, 7, 3'h0);
    run(1'b0, 1, 3'h0);
    chk(ram.mem[dn - 16'h7d], 16'h3000);
    setup(1'b0, 16'h4880, 16'h6000, 16'h0f00);
    run(1'b0, 32, 3'h0);
    e_info = 16'h0ffe;
    ram.mem[dn + 16'h3] = e_info;
    run(1'b0, 2, 3'h0);
    // mid-run reset clears settings and the block count
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(3'h0, d);
    chk(d, 16'h0);
    rd(3'h4, d);
    chk(d, 16'h0);
    e_blk = 16'h0;
    wr(3'h1, 16'h0100);
    // interrupt and discard off: errored data kept, block completes silently
    wr(3'h0, 16'h0);
    irq_en = 1'b0;
    disc = 1'b0;
    setup(1'b0, 16'h4820, 16'h7000, 16'h7102);
    run(1'b0, 3, 3'h1);
    run(1'b0, 3, 3'h0);
    rd(3'h4, d);
    chk(d, e_blk);
    rd(3'h3, d);
    chk(d, e_info);
    close_out();
  end
endmodule : tb
